/* File: hdl/sppc_top.sv */
// sampled three-term process controller for a motor drive
// assumes samples and panel strobes come from logic on REF_CLK;
// only the external loop select pin is asynchronous
`timescale 1ns/10ps

// Behaviour
// - output is 100/band times error, integral and derivative terms, plus feed-forward
// - one sample and one output update every 50 ms
// - proportional band is limited to 0.1 to 999.9 percent
// - integral time is limited to 0.05 to 19.99 seconds per repeat
// - derivative time is limited to 0.25 to 5.00 seconds
// - integrator limits within plus or minus 100 percent, clamp flagged
// - output limits within plus or minus 100 percent, output held inside
// - limits and presets are signed, negative means reverse direction
// - feed-forward picks zero, input one, speed knob or six presets
// - settings are signed with plus or minus 32767 steps
// - analog samples are 10 bit, 1024 steps
// - flags for integrator saturation, output saturation, high and low alarm
// - process alarms appear within 60 ms of the condition
// - analog output carries process value, integrator or output, with span
// - loop closed or open by external pin if enabled, else panel buttons
// - optional output negation, off by default
// - master enable off means no frequency demand is driven
// - process value from input two, feed-forward may use input one
// - setpoint from terminal selection or knob when knob assigned
// - enabled, closed loop and stopped drive loads integrator preset
// - integrator at a limit holds until error changes sign
// - output at upper limit stops integration while error is positive, at lower limit while error is negative
module sppc_top #(
  parameter int SAMPLE_CYCLES = sppc_pkg::SAMPLE_CYCLES  // clocks per sample
) (
  input  wire logic                    REF_CLK,           // 20 MHz clock
  input  wire logic                    RST,               // async reset
  input  wire sppc_pkg::sppc_cfg_s     CFG,               // settings
  input  wire logic [9:0]              AIN1_SAMPLE,       // analog input 1
  input  wire logic [9:0]              AIN2_SAMPLE,       // process value
  input  wire logic [9:0]              KNOB_SAMPLE,       // speed knob
  input  wire sppc_pkg::sppc_val_t     SETPOINT_EXT,      // terminal setpoint
  input  wire logic                    KNOB_IN_AUTO,      // knob is setpoint
  input  wire sppc_pkg::sppc_presets_t PRESETS,           // presets 1..6
  input  wire logic                    EXT_LOOP_PIN,      // 1 = closed loop
  input  wire logic                    AUTO_BTN,          // panel auto strobe
  input  wire logic                    MAN_BTN,           // panel manual strobe
  input  wire logic                    DRIVE_RUNNING,     // drive is running
  output sppc_pkg::sppc_val_t          FREQ_DEMAND,       // frequency demand
  output logic                         FREQ_DEMAND_VALID, // demand driven
  output logic                         CLOSED_LOOP,       // loop state
  output sppc_pkg::sppc_flags_s        FLAGS,             // digital flags
  output logic [9:0]                   ANALOG_OUT         // analog output code
);

  sppc_pkg::sppc_state_s st_r;
  sppc_pkg::sppc_state_s st_nxt;

  logic                ext_loop_s;
  logic                tick;
  logic [13:0]         pb_eff;
  logic [10:0]         ti_eff;
  logic [8:0]          td_eff;
  sppc_pkg::sppc_val_t i_hi_f, i_lo_f, o_hi_f, o_lo_f, pre_f;
  sppc_pkg::sppc_val_t sp_val, ff_val, ao_val;
  logic                preset_mode, freeze;
  logic signed [23:0]  inc;
  logic signed [24:0]  icand;
  logic signed [31:0]  dterm;
  logic signed [47:0]  scaled;
  logic signed [47:0]  ocand;
  logic signed [32:0]  ao_prod;
  sppc_pkg::sppc_val_t integ_new, out_new;
  logic                i_at_hi, i_at_lo, o_at_hi, o_at_lo;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic sppc_pkg::sppc_val_t to_steps(input logic [9:0] s);
    to_steps = {6'h00, s} << sppc_pkg::ADC_SHIFT;
  endfunction : to_steps

  function automatic sppc_pkg::sppc_val_t lim_fix(input sppc_pkg::sppc_val_t v);
    lim_fix = (v < sppc_pkg::LIM_MIN) ? sppc_pkg::LIM_MIN : v;
  endfunction : lim_fix

  sppc_sync #(.W(1)) u_loop_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   (EXT_LOOP_PIN),
    .q   (ext_loop_s)
  );

  assign tick = st_r.div == 20'(SAMPLE_CYCLES - 1);

  // -----------------------------------------------------------------
  // setting conditioning and source selection
  // -----------------------------------------------------------------
  always_comb begin
    pb_eff = (CFG.pb > sppc_pkg::PB_MAX) ? sppc_pkg::PB_MAX
           : (CFG.pb < sppc_pkg::PB_MIN) ? sppc_pkg::PB_MIN : CFG.pb;
    ti_eff = CFG.ti;
    if (CFG.ti != 11'h000 && CFG.ti < sppc_pkg::TI_MIN) begin
      ti_eff = sppc_pkg::TI_MIN;
    end else if (CFG.ti > sppc_pkg::TI_MAX) begin
      ti_eff = sppc_pkg::TI_MAX;
    end
    td_eff = CFG.td;
    if (CFG.td != 9'h000 && CFG.td < sppc_pkg::TD_MIN) begin
      td_eff = sppc_pkg::TD_MIN;
    end else if (CFG.td > sppc_pkg::TD_MAX) begin
      td_eff = sppc_pkg::TD_MAX;
    end
    i_hi_f = lim_fix(CFG.i_hi);
    i_lo_f = lim_fix(CFG.i_lo);
    o_hi_f = lim_fix(CFG.o_hi);
    o_lo_f = lim_fix(CFG.o_lo);
    pre_f  = lim_fix(CFG.preset);
    sp_val = KNOB_IN_AUTO ? to_steps(KNOB_SAMPLE) : SETPOINT_EXT;
    case (CFG.ff_sel)
      sppc_pkg::FF_AIN1:    ff_val = to_steps(AIN1_SAMPLE);
      sppc_pkg::FF_KNOB:    ff_val = to_steps(KNOB_SAMPLE);
      sppc_pkg::FF_PRESET1: ff_val = $signed(PRESETS[0]);
      sppc_pkg::FF_PRESET2: ff_val = $signed(PRESETS[1]);
      sppc_pkg::FF_PRESET3: ff_val = $signed(PRESETS[2]);
      sppc_pkg::FF_PRESET4: ff_val = $signed(PRESETS[3]);
      sppc_pkg::FF_PRESET5: ff_val = $signed(PRESETS[4]);
      sppc_pkg::FF_PRESET6: ff_val = $signed(PRESETS[5]);
      default:              ff_val = '0;
    endcase
  end

  // -----------------------------------------------------------------
  // three-term arithmetic
  // -----------------------------------------------------------------
  always_comb begin
    preset_mode = CFG.enable && st_r.closed && !DRIVE_RUNNING;
    freeze = (st_r.out_hi && st_r.err > 0)
          || (st_r.out_lo && st_r.err < 0);
    inc = '0;
    if (ti_eff != 11'h000) begin
      inc = 24'(st_r.err) * 24'(sppc_pkg::TS_HUND) / $signed({13'h0000, ti_eff});
    end
    if (ti_eff == 11'h000) begin
      icand = '0;
    end else if (preset_mode) begin
      icand = 25'(pre_f);
    end else if (freeze) begin
      icand = 25'(st_r.integ);
    end else begin
      icand = 25'(st_r.integ) + 25'(inc);
    end
    dterm = '0;
    if (td_eff != 9'h000) begin
      dterm = 32'(18'(st_r.err) - 18'(st_r.err_prev)) * $signed(32'(td_eff))
            / 32'(sppc_pkg::TS_HUND);
    end
    scaled = st_r.sum * 48'(sppc_pkg::PB_UNITY)
           / $signed({34'h0, pb_eff}) + 48'(ff_val);
    ocand = CFG.invert ? -scaled : scaled;
  end

  sppc_clamp #(.IW(25)) u_integ_clamp (
    .x     (icand),
    .lo    (i_lo_f),
    .hi    (i_hi_f),
    .y     (integ_new),
    .at_hi (i_at_hi),
    .at_lo (i_at_lo)
  );

  sppc_clamp #(.IW(48)) u_out_clamp (
    .x     (ocand),
    .lo    (o_lo_f),
    .hi    (o_hi_f),
    .y     (out_new),
    .at_hi (o_at_hi),
    .at_lo (o_at_lo)
  );

  // -----------------------------------------------------------------
  // analog output source and span
  // -----------------------------------------------------------------
  always_comb begin
    case (CFG.ao_sel)
      sppc_pkg::AO_PV:    ao_val = st_r.pv;
      sppc_pkg::AO_INTEG: ao_val = st_r.integ;
      default:            ao_val = out_new;
    endcase
    ao_prod = (33'(ao_val) * $signed({17'h00000, CFG.ao_span}))
            >>> sppc_pkg::AO_SHIFT;
  end

  // -----------------------------------------------------------------
  // next state: divider, loop mode, sample sequence
  // -----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    st_nxt.div = tick ? '0 : st_r.div + 20'h00001;
    if (MAN_BTN) begin
      st_nxt.auto_mode = 1'b0;
    end else if (AUTO_BTN) begin
      st_nxt.auto_mode = 1'b1;
    end
    st_nxt.closed = CFG.ext_loop_en ? ext_loop_s : st_r.auto_mode;
    case (st_r.st)
      sppc_pkg::ST_IDLE: begin
        if (tick) begin
          st_nxt.pv  = to_steps(AIN2_SAMPLE);
          st_nxt.err = 17'(sp_val) - 17'(to_steps(AIN2_SAMPLE));
          st_nxt.st  = sppc_pkg::ST_CALC;
        end
      end
      sppc_pkg::ST_CALC: begin
        st_nxt.integ    = integ_new;
        st_nxt.err_prev = st_r.err;
        st_nxt.sum      = 48'(st_r.err) + 48'(integ_new) + 48'(dterm);
        st_nxt.flags.integrator_saturated_flag = i_at_hi || i_at_lo;
        st_nxt.flags.process_high_alarm = st_r.pv > CFG.alarm_hi;
        st_nxt.flags.process_low_alarm  = st_r.pv < CFG.alarm_lo;
        st_nxt.st = sppc_pkg::ST_OUTP;
      end
      sppc_pkg::ST_OUTP: begin
        st_nxt.demand       = out_new;
        st_nxt.demand_valid = 1'b1;
        st_nxt.out_hi       = o_at_hi;
        st_nxt.out_lo       = o_at_lo;
        st_nxt.flags.output_saturated_flag = o_at_hi || o_at_lo;
        st_nxt.ao = (ao_prod < 0) ? 10'h000
                  : (ao_prod > 33'(sppc_pkg::AO_MAX)) ? sppc_pkg::AO_MAX
                  : ao_prod[9:0];
        st_nxt.st = sppc_pkg::ST_IDLE;
      end
      default: st_nxt.st = sppc_pkg::ST_IDLE;
    endcase
    if (!CFG.enable || !st_r.closed) begin
      st_nxt.demand_valid = 1'b0;
      st_nxt.demand       = '0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign FREQ_DEMAND       = st_r.demand;
  assign FREQ_DEMAND_VALID = st_r.demand_valid;
  assign CLOSED_LOOP       = st_r.closed;
  assign FLAGS             = st_r.flags;
  assign ANALOG_OUT        = st_r.ao;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_sample;
    @(posedge REF_CLK) disable iff (RST)
    tick |=> st_r.st == sppc_pkg::ST_CALC ##1 st_r.st == sppc_pkg::ST_OUTP;
  endproperty
  a_sample: assert property (p_sample) else $error("sample sequence broken");

  property p_disable;
    @(posedge REF_CLK) disable iff (RST)
    !CFG.enable |=> !FREQ_DEMAND_VALID && FREQ_DEMAND == 16'sh0000;
  endproperty
  a_disable: assert property (p_disable) else $error("demand while off");

  property p_out_lim;
    @(posedge REF_CLK) disable iff (RST)
    st_r.st == sppc_pkg::ST_OUTP && CFG.enable && st_r.closed && o_lo_f <= o_hi_f
    |=> FREQ_DEMAND <= $past(o_hi_f) && FREQ_DEMAND >= $past(o_lo_f);
  endproperty
  a_out_lim: assert property (p_out_lim) else $error("demand outside limits");

  property p_preset;
    @(posedge REF_CLK) disable iff (RST)
    st_r.st == sppc_pkg::ST_CALC && preset_mode && ti_eff != 11'h000
    && i_lo_f <= pre_f && pre_f <= i_hi_f |=> st_r.integ == $past(pre_f);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");

  property p_hold;
    @(posedge REF_CLK) disable iff (RST)
    st_r.st == sppc_pkg::ST_CALC && !preset_mode && ti_eff != 11'h000
    && st_r.integ == i_hi_f && st_r.err >= 0 && i_lo_f < i_hi_f
    |=> st_r.integ == $past(i_hi_f);
  endproperty
  a_hold: assert property (p_hold) else $error("integrator left limit");

  property p_alarm_resp;
    @(posedge REF_CLK) disable iff (RST)
    tick && st_r.st == sppc_pkg::ST_IDLE && to_steps(AIN2_SAMPLE) > CFG.alarm_hi
    ##1 $stable(CFG.alarm_hi) |=> FLAGS.process_high_alarm;
  endproperty
  a_alarm_resp: assert property (p_alarm_resp) else $error("high alarm late");

  property p_alarm_lo;
    @(posedge REF_CLK) disable iff (RST)
    st_r.st == sppc_pkg::ST_CALC |=>
    FLAGS.process_low_alarm == ($past(st_r.pv) < $past(CFG.alarm_lo));
  endproperty
  a_alarm_lo: assert property (p_alarm_lo) else $error("low alarm wrong");

  property p_isat;
    @(posedge REF_CLK) disable iff (RST)
    st_r.st == sppc_pkg::ST_OUTP |-> FLAGS.integrator_saturated_flag ==
    (st_r.integ >= $past(i_hi_f) || st_r.integ <= $past(i_lo_f));
  endproperty
  a_isat: assert property (p_isat) else $error("integrator flag wrong");

  property p_invert;
    @(posedge REF_CLK) disable iff (RST)
    st_r.st == sppc_pkg::ST_OUTP && CFG.enable && st_r.closed && CFG.invert
    && -scaled > 48'(o_lo_f) && -scaled < 48'(o_hi_f)
    |=> FREQ_DEMAND == 16'(-$past(scaled));
  endproperty
  a_invert: assert property (p_invert) else $error("output not negated");

  property p_pb;
    @(posedge REF_CLK) disable iff (RST)
    pb_eff <= sppc_pkg::PB_MAX && pb_eff >= sppc_pkg::PB_MIN
    && (CFG.pb > sppc_pkg::PB_MAX || CFG.pb < sppc_pkg::PB_MIN || pb_eff == CFG.pb);
  endproperty
  a_pb: assert property (p_pb) else $error("band out of range");

endmodule : sppc_top

/* File: hdl/sppc_pkg.sv */
// sampled three-term process controller: shared constants and types
// assumes a single 20 MHz clock and 10-bit converter samples
package sppc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;             // clock rate
  localparam int SAMPLE_MS     = 50;                     // sample period
  localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int TS_HUND       = SAMPLE_MS / 10;         // period in 0.01 s

  // ----------------------------------------------------------------
  // number formats and setting ranges
  // ----------------------------------------------------------------
  localparam int                 ADC_SHIFT  = 5;         // 10 bit to 15 bit
  localparam int                 PB_UNITY   = 1000;      // 100.0 % in 0.1 %
  localparam logic        [13:0] PB_MAX     = 14'h270F;  // 999.9 %
  localparam logic        [13:0] PB_MIN     = 14'h0001;  // avoids divide by 0
  localparam logic        [10:0] TI_MIN     = 11'h005;   // 0.05 s/r
  localparam logic        [10:0] TI_MAX     = 11'h7CF;   // 19.99 s/r
  localparam logic        [8:0]  TD_MIN     = 9'h019;    // 0.25 s
  localparam logic        [8:0]  TD_MAX     = 9'h1F4;    // 5.00 s
  localparam logic signed [15:0] LIM_MAX    = 16'sh7FFF; // +100 %
  localparam logic signed [15:0] LIM_MIN    = 16'sh8001; // -100 %
  localparam int                 AO_SHIFT   = 15;        // span 0x0400 = 1.0
  localparam logic        [9:0]  AO_MAX     = 10'h3FF;   // top output code

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic signed [15:0] sppc_val_t;
  typedef logic [5:0][15:0] sppc_presets_t;

  typedef enum logic [3:0] {
    FF_ZERO, FF_AIN1, FF_KNOB, FF_PRESET1, FF_PRESET2,
    FF_PRESET3, FF_PRESET4, FF_PRESET5, FF_PRESET6
  } sppc_ff_e;

  typedef enum logic [1:0] {AO_PV, AO_INTEG, AO_OUT} sppc_ao_e;

  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_OUTP} sppc_st_e;

  typedef struct packed {
    logic        enable;      // master enable
    logic        ext_loop_en; // external loop select pin in use
    logic        invert;      // negate output
    sppc_ff_e    ff_sel;      // feed-forward source
    sppc_ao_e    ao_sel;      // analog output source
    logic [15:0] ao_span;     // analog output gain
    logic [13:0] pb;          // proportional band, 0.1 %
    logic [10:0] ti;          // integral time, 0.01 s/r, 0 = off
    logic [8:0]  td;          // derivative time, 0.01 s, 0 = off
    sppc_val_t   preset;      // integrator preset
    sppc_val_t   i_hi;        // integrator limits
    sppc_val_t   i_lo;
    sppc_val_t   o_hi;        // output limits
    sppc_val_t   o_lo;
    sppc_val_t   alarm_hi;    // process alarm thresholds
    sppc_val_t   alarm_lo;
  } sppc_cfg_s;

  typedef struct packed {
    logic integrator_saturated_flag;
    logic output_saturated_flag;
    logic process_high_alarm;
    logic process_low_alarm;
  } sppc_flags_s;

  typedef struct packed {
    sppc_st_e           st;
    logic        [19:0] div;
    logic               auto_mode;
    logic               closed;
    logic signed [16:0] err;
    logic signed [16:0] err_prev;
    sppc_val_t          pv;
    sppc_val_t          integ;
    logic signed [47:0] sum;
    sppc_val_t          demand;
    logic               demand_valid;
    logic               out_hi;
    logic               out_lo;
    sppc_flags_s        flags;
    logic        [9:0]  ao;
  } sppc_state_s;

endpackage : sppc_pkg

/* File: hdl/sppc_sync.sv */
// two flip-flop synchroniser for pin levels
// assumes inputs are levels that may change at any time
`timescale 1ns/10ps
module sppc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // block clock
  input  wire logic         rst,  // async reset, active high
  input  wire logic [W-1:0] d,    // raw pin level
  output logic      [W-1:0] q     // synchronised level
);

  logic [1:0][W-1:0] stage_r;
  logic [1:0][W-1:0] stage_nxt;

  // -----------------------------------------------------------------
  // shift chain
  // -----------------------------------------------------------------
  always_comb begin
    stage_nxt = {stage_r[0], d};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign q = stage_r[1];

endmodule : sppc_sync

/* File: hdl/sppc_clamp.sv */
// signed saturating clamp to a 16-bit window
// assumes lo <= hi; if not, x at or above hi gives hi and x below hi gives lo
`timescale 1ns/10ps
module sppc_clamp #(
  parameter int IW = 18
) (
  input  wire logic signed [IW-1:0] x,      // value to clamp
  input  wire sppc_pkg::sppc_val_t  lo,     // lower limit
  input  wire sppc_pkg::sppc_val_t  hi,     // upper limit
  output sppc_pkg::sppc_val_t       y,      // clamped value
  output logic                      at_hi,  // at or above upper limit
  output logic                      at_lo   // at or below lower limit
);

  logic signed [IW-1:0] lo_x;
  logic signed [IW-1:0] hi_x;

  // -----------------------------------------------------------------
  // compare and select
  // -----------------------------------------------------------------
  always_comb begin
    lo_x  = IW'(lo);
    hi_x  = IW'(hi);
    at_hi = x >= hi_x;
    at_lo = x <= lo_x;
    if (at_hi) begin
      y = hi;
    end else if (at_lo) begin
      y = lo;
    end else begin
      y = x[15:0];
    end
  end

endmodule : sppc_clamp

/* File: testbench/sppc_xdcr.sv */
// process transducer and frequency demand stage seen from the controller
// assumes the bench sets the process code and both share the block clock
`timescale 1ns/10ps
module sppc_xdcr (
  input  wire logic                clk,      // block clock
  input  wire logic [9:0]          pv_code,  // process level to present
  input  wire sppc_pkg::sppc_val_t demand,   // frequency demand in
  input  wire logic                valid,    // demand driven
  output logic      [9:0]          ain2,     // second analog input
  output sppc_pkg::sppc_val_t      speed     // last demand acted on
);
  // transducer output moves off the sampling edge
  initial ain2 = 10'h000;
  always @(negedge clk) ain2 <= pv_code;
  // motor stage keeps the last driven demand, ignores undriven values
  initial speed = 16'sh0000;
  always @(posedge clk) if (valid === 1'b1) speed <= demand;
endmodule : sppc_xdcr

/* File: testbench/tb_top.sv */
// bench for the sampled process controller: tests as call sequences
// assumes the design package and top module are compiled first
`timescale 1ns/10ps
module tb_top;
  localparam int SC = 16;
  logic                    ref_clk   = 1'b0;
  logic                    rst       = 1'b1;
  sppc_pkg::sppc_cfg_s     cfg;
  logic [9:0]              ain1      = 10'h000;
  logic [9:0]              knob      = 10'h000;
  logic [9:0]              pv_code   = 10'h100;
  logic [9:0]              ain2;
  sppc_pkg::sppc_val_t     sp        = 16'sh4000;
  logic                    knob_auto = 1'b0;
  sppc_pkg::sppc_presets_t presets;
  logic                    pin       = 1'b0;
  logic                    auto_b    = 1'b0;
  logic                    man_b     = 1'b0;
  logic                    running   = 1'b0;
  sppc_pkg::sppc_val_t     demand;
  sppc_pkg::sppc_val_t     speed;
  logic                    valid;
  logic                    closed;
  sppc_pkg::sppc_flags_s   flags;
  logic [9:0]              ao;
  int                      num_errors = 0;
  int                      n_compared = 0;
  always #25 ref_clk = ~ref_clk;
  sppc_top #(.SAMPLE_CYCLES(SC)) u_sppc_top (.REF_CLK(ref_clk), .RST(rst), .CFG(cfg),
    .AIN1_SAMPLE(ain1), .AIN2_SAMPLE(ain2), .KNOB_SAMPLE(knob), .SETPOINT_EXT(sp),
    .KNOB_IN_AUTO(knob_auto), .PRESETS(presets), .EXT_LOOP_PIN(pin), .AUTO_BTN(auto_b),
    .MAN_BTN(man_b), .DRIVE_RUNNING(running), .FREQ_DEMAND(demand),
    .FREQ_DEMAND_VALID(valid), .CLOSED_LOOP(closed), .FLAGS(flags), .ANALOG_OUT(ao));
  sppc_xdcr u_sppc_xdcr (.clk(ref_clk), .pv_code(pv_code), .demand(demand), .valid(valid),
    .ain2(ain2), .speed(speed));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // three sample periods so any mid-sample change has settled
  task automatic run(input logic [15:0] exp_d, input logic [3:0] exp_f);
    repeat (3 * SC) @(negedge ref_clk);
    chk(demand, exp_d);
    chk(16'(flags), 16'(exp_f));
  endtask : run
  // one-cycle panel strobe, launched on a falling edge
  task automatic press();
    @(negedge ref_clk) auto_b = 1'b1;
    @(negedge ref_clk) auto_b = 1'b0;
    @(negedge ref_clk);
  endtask : press
  task automatic results();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // watchdog well past the expected run time
  initial begin
    #400_000;
    num_errors++;
    results();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    cfg = '{enable: 1'b1, ext_loop_en: 1'b0, invert: 1'b0, ff_sel: sppc_pkg::FF_ZERO,
      ao_sel: sppc_pkg::AO_PV, ao_span: 16'h0400, pb: 14'h03E8, ti: 11'h000, td: 9'h000,
      preset: 16'sh0000, i_hi: 16'sh7FFF, i_lo: 16'sh8001, o_hi: 16'sh7FFF, o_lo: 16'sh8001,
      alarm_hi: 16'sh7000, alarm_lo: 16'sh0100};
    for (int i = 0; i < 6; i++) presets[i] = 16'(16'h0100 * (i + 1));
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    run(16'h0000, 4'h0);
    chk(16'(valid), 16'h0000);
    chk(16'(closed), 16'h0000);
    press();
    chk(16'(closed), 16'h0001);
    run(16'h2000, 4'h0);
    chk(16'(valid), 16'h0001);
    chk(16'(ao), 16'h0100);
    chk(speed, 16'h2000);
    cfg.pb = 14'h07D0;
    run(16'h1000, 4'h0);
    cfg.pb = 14'h0000;
    run(16'h7FFF, 4'h4);
    cfg.pb = 14'h03E8;
    cfg.invert = 1'b1;
    run(16'hE000, 4'h0);
    cfg.o_lo = 16'shF000;
    run(16'hF000, 4'h4);
    cfg.invert = 1'b0;
    cfg.o_lo = 16'sh8001;
    cfg.o_hi = 16'sh1000;
    run(16'h1000, 4'h4);
    cfg.o_hi = 16'sh7FFF;
    cfg.ao_sel = sppc_pkg::AO_OUT;
    cfg.ao_span = 16'h0800;
    run(16'h2000, 4'h0);
    chk(16'(ao), 16'h0200);
    // zero error, so the demand is the feed-forward alone
    sp = 16'sh2000;
    for (int i = 0; i < 6; i++) begin
      cfg.ff_sel = sppc_pkg::sppc_ff_e'(4'(i + 3));
      run(presets[i], 4'h0);
    end
    ain1 = 10'h040;
    knob = 10'h020;
    cfg.ff_sel = sppc_pkg::FF_AIN1;
    run(16'h0800, 4'h0);
    cfg.ff_sel = sppc_pkg::FF_KNOB;
    run(16'h0400, 4'h0);
    cfg.ff_sel = sppc_pkg::FF_ZERO;
    knob = 10'h200;
    knob_auto = 1'b1;
    run(16'h2000, 4'h0);
    knob_auto = 1'b0;
    pv_code = 10'h3C0;
    run(16'hA800, 4'h2);
    pv_code = 10'h004;
    run(16'h1F80, 4'h1);
    pv_code = 10'h100;
    // integrator preset while stopped, then clamp once running
    cfg.ti = 11'h064;
    cfg.i_hi = 16'sh0900;
    cfg.preset = 16'sh0800;
    cfg.ao_sel = sppc_pkg::AO_INTEG;
    run(16'h0800, 4'h0);
    chk(16'(ao), 16'h0080);
    sp = 16'sh4000;
    running = 1'b1;
    run(16'h2900, 4'h8);
    sp = 16'sh1000;
    repeat (3 * SC) @(negedge ref_clk);
    chk(16'(flags), 16'h0000);
    cfg.enable = 1'b0;
    run(16'h0000, 4'h0);
    chk(16'(valid), 16'h0000);
    cfg.enable = 1'b1;
    cfg.ext_loop_en = 1'b1;
    press();
    run(16'h0000, 4'h0);
    chk(16'(closed), 16'h0000);
    pin = 1'b1;
    repeat (3 * SC) @(negedge ref_clk);
    chk(16'(closed), 16'h0001);
    // derivative kick on an error step, integrator off
    cfg.ti = 11'h000;
    cfg.td = 9'h019;
    sp = 16'sh2000;
    run(16'h0000, 4'h0);
    sp = 16'sh1F00;
    for (int k = 0; k < SC + 4 && demand === 16'h0000; k++) @(negedge ref_clk);
    chk(demand, 16'hFA00);
    run(16'hFF00, 4'h0);
    results();
  end
endmodule : tb_top
